// ### rtl/rfb_pkg.sv
// Shared constants for the receive flow-control backpressure block
package rfb_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 25;     // 40 MHz controller clock
   localparam int unsigned JAM_SHORT_NS   = 5000;   // Step for codes 0h..2h
   localparam int unsigned JAM_CODE3_NS   = 25000;  // Code 3h
   localparam int unsigned JAM_STEP_NS    = 50000;  // Step for codes 4h..Fh
   localparam int unsigned JAM_10M_ADD_NS = 2200;   // Extra time at 10 Mb/s
   localparam int unsigned FILL_UNIT_B    = 64;     // Threshold granularity in bytes

   // ----------------------------------------------------------------
   // Register map (byte addresses) and field layout
   // ----------------------------------------------------------------
   localparam logic [7:0] CFG_OFS  = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam int unsigned CFG_HI_LSB   = 16;
   localparam int unsigned CFG_LO_LSB   = 8;
   localparam int unsigned CFG_JAM_LSB  = 4;
   localparam int unsigned CFG_ANY_BIT  = 0;
   localparam logic [31:0] CFG_RST      = 32'h0000_0000;
   localparam logic [31:0] CFG_WR_MASK  = 32'h00FF_FFF1;
   localparam int unsigned STAT_JAM_BIT  = 0;
   localparam int unsigned STAT_PEND_BIT = 1;
   localparam int unsigned STAT_HELD_BIT = 2;
   localparam int unsigned STAT_HI_BIT   = 3;
   localparam int unsigned STAT_ZERO_BIT = 4;

   // ----------------------------------------------------------------
   // Full-duplex pause state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_WATCH = 2'b01,   // No high-mark pause in force; a zero-time pause may still be pending
      ST_HELD  = 2'b10    // Pause requested, waiting for fill to fall below low mark
   } rfb_state_e;

   // Jam duration in ns for a code at 100 Mb/s, or at 10 Mb/s when fast is low
   function automatic int unsigned rfb_jam_ns(input logic [3:0] code, input logic fast);
      int unsigned t;
      t = 0;
      if (code < 4'h3) begin
         t = (int'(code) + 1) * JAM_SHORT_NS;
      end else if (code == 4'h3) begin
         t = JAM_CODE3_NS;
      end else begin
         t = (int'(code) - 3) * JAM_STEP_NS;
      end
      if (!fast) begin
         t = t + JAM_10M_ADD_NS;
      end
      return t;
   endfunction

endpackage

// ### rtl/rfb_jam_timer.sv
// Backpressure duration timer counting the selected jam time in clock cycles
`timescale 1ns/1ps
module rfb_jam_timer
   import rfb_pkg::*;
#(
   parameter int unsigned NS_PER_CYC = CLK_PERIOD_NS, // Raise to shorten runs in simulation
   parameter int unsigned CNT_W      = 16
) (
   input  wire logic       clk_i,      // Controller clock
   input  wire logic       rst_i,      // Synchronous reset, active high
   input  wire logic       start_i,    // Begin a jam period
   input  wire logic [3:0] code_i,     // Duration code
   input  wire logic       fast_i,     // High at 100 Mb/s
   input  wire logic       abort_i,    // Drop the jam at once
   output logic            busy_o      // Jam in progress
);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W-1:0] load_cyc;
   int unsigned      cyc;

   // ----------------------------------------------------------------
   // Load value: ns rounded down to cycles, never below one
   // ----------------------------------------------------------------
   always_comb begin
      cyc = rfb_jam_ns(code_i, fast_i) / NS_PER_CYC;
      if (cyc == 0) begin
         cyc = 1;
      end
      load_cyc = CNT_W'(cyc);
   end

   // Count down; a start while busy is ignored so a jam is never stretched
   always_comb begin
      cnt_d = cnt_q;
      if (abort_i) begin
         cnt_d = '0;
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - CNT_W'(1);                      // (RQ12)
      end else if (start_i) begin
         cnt_d = load_cyc;                               // (RQ7)
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign busy_o = (cnt_q != '0);                        // (RQ10)

endmodule

// ### rtl/rfb_flow_ctl.sv
// Automatic receive flow control: half-duplex jam and full-duplex pause requests
`timescale 1ns/1ps

// Notes on behaviour
// (RQ1) With any-frame set, reaching the high mark leads to jam or pause frame.
// (RQ2) Full-duplex pause requests only happen with the any-frame option set.
// (RQ3) Half-duplex jam decision ignores the destination address entirely.
// (RQ4) Half-duplex jam starts on a valid preamble after the high mark is reached.
// (RQ5) Full-duplex pause request is raised in the cycle the high mark is reached.
// (RQ6) A pause request stays pending until the transmitter takes it between frames.
// (RQ7) Duration code picks 5..600 us at 100 Mb/s, plus 2.2 us at 10 Mb/s.
// (RQ8) High and low marks count in units of 64 bytes of receive data.
// (RQ9) After a high-mark pause, a zero-time pause follows once below the low mark.
// (RQ10) Jam lasts the selected duration; the code is unused in full duplex.
// (RQ11) No pause frames and no jam while the transmitter is disabled.
// (RQ12) Timer counts cycles and releases jam; new triggers only after it ends.
module rfb_flow_ctl
   import rfb_pkg::*;
#(
   parameter int unsigned FILL_W     = 14,            // Receive FIFO level width in bits; the level counts bytes
   parameter int unsigned NS_PER_CYC = CLK_PERIOD_NS  // Jam timer scaling
) (
   input  wire logic              clk_i,          // Controller clock
   input  wire logic              rst_i,          // Synchronous reset, active high
   // Wishbone classic slave
   input  wire logic              wb_cyc_i,       // Bus cycle
   input  wire logic              wb_stb_i,       // Strobe
   input  wire logic              wb_we_i,        // Write enable
   input  wire logic [7:0]        wb_adr_i,       // Byte address
   input  wire logic [3:0]        wb_sel_i,       // Byte lanes
   input  wire logic [31:0]       wb_dat_i,       // Write data
   output logic      [31:0]       wb_dat_o,       // Read data
   output logic                   wb_ack_o,       // Acknowledge
   // MAC and receive FIFO side
   input  wire logic [FILL_W-1:0] rx_fill_bytes_i, // Bytes held in receive FIFO
   input  wire logic              full_duplex_i,  // Link in full duplex
   input  wire logic              speed_100_i,    // Link at 100 Mb/s
   input  wire logic              tx_enabled_i,   // Transmitter enabled
   input  wire logic              rx_preamble_i,  // Valid preamble seen, one-cycle pulse
   input  wire logic              pause_take_i,   // Transmitter takes pending pause
   output logic                   pause_req_o,    // Pause frame wanted
   output logic                   pause_zero_o,   // Requested pause carries zero time
   output logic                   jam_o           // Backpressure onto the link
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [31:0] cfg_q, cfg_d;
   logic [31:0] rdat_q, rdat_d;
   logic        ack_q, ack_d;
   rfb_state_e  st_q, st_d;
   logic        pend_q, pend_d;
   logic        zero_q, zero_d;
   logic        hi_q, hi_d;

   logic [7:0]  hi_mark;
   logic [7:0]  lo_mark;
   logic [3:0]  jam_code;
   logic        any_en;
   logic        hi_now;
   logic        lo_now;
   logic        fd_trig;
   logic        zero_trig;
   logic        jam_start;
   logic        jam_busy;
   logic        bus_req;

   // Fill level compare against a mark in 64-byte units
   function automatic logic at_or_above(input logic [FILL_W-1:0] lvl, input logic [7:0] mark);
      logic [FILL_W+8:0] lim;
      lim = (FILL_W+9)'(mark) * (FILL_W+9)'(FILL_UNIT_B);
      return (FILL_W+9)'(lvl) >= lim;
   endfunction

   assign hi_mark  = cfg_q[CFG_HI_LSB +: 8];
   assign lo_mark  = cfg_q[CFG_LO_LSB +: 8];
   assign jam_code = cfg_q[CFG_JAM_LSB +: 4];
   assign any_en   = cfg_q[CFG_ANY_BIT];

   // ----------------------------------------------------------------
   // Threshold detection
   // ----------------------------------------------------------------
   // Level crossing compare; a zero high mark counts as always reached.
   // The registered copy feeds status only, so it may lag by one cycle.
   always_comb begin
      hi_now  = at_or_above(rx_fill_bytes_i, hi_mark);          // (RQ8)
      lo_now  = !at_or_above(rx_fill_bytes_i, lo_mark);         // (RQ8)
      hi_d    = hi_now;
   end

   // ----------------------------------------------------------------
   // Full-duplex pause control
   // ----------------------------------------------------------------
   // Only the any-frame bit arms full-duplex flow control
   always_comb begin
      fd_trig   = any_en && full_duplex_i && tx_enabled_i        // (RQ2) (RQ11)
                  && st_q == ST_WATCH && hi_now;                  // (RQ5)
      zero_trig = any_en && full_duplex_i && tx_enabled_i
                  && st_q == ST_HELD && lo_now && !pend_q;        // (RQ9)
      st_d   = st_q;
      pend_d = pend_q;
      zero_d = zero_q;
      if (!tx_enabled_i) begin
         pend_d = 1'b0;                                            // (RQ11)
      end else if (pend_q && pause_take_i) begin
         pend_d = 1'b0;                                            // (RQ6)
      end
      case (st_q)
         ST_WATCH: begin
            if (fd_trig) begin
               st_d   = ST_HELD;                                   // (RQ1)
               pend_d = 1'b1;
               zero_d = 1'b0;
            end
         end
         ST_HELD: begin
            if (zero_trig) begin
               st_d   = ST_WATCH;
               pend_d = 1'b1;
               zero_d = 1'b1;
            end else if (!any_en || !full_duplex_i) begin
               st_d = ST_WATCH;
            end
         end
         default: begin
            st_d = ST_WATCH;
         end
      endcase
   end

   // Request is live in the trigger cycle itself, then held until taken
   assign pause_req_o  = tx_enabled_i && (pend_q || fd_trig || zero_trig); // (RQ5) (RQ6)
   assign pause_zero_o = (pend_q && zero_q) || zero_trig;

   // ----------------------------------------------------------------
   // Half-duplex jam
   // ----------------------------------------------------------------
   // Preamble alone decides; the address is never looked at, which lets the jam
   // land before any byte of the frame reaches the FIFO
   assign jam_start = any_en && !full_duplex_i && tx_enabled_i    // (RQ3) (RQ11)
                      && hi_now && rx_preamble_i && !jam_busy;    // (RQ4) (RQ12)

   rfb_jam_timer #(
      .NS_PER_CYC (NS_PER_CYC),
      .CNT_W      (16)
   ) u_timer (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (jam_start),
      .code_i  (jam_code),
      .fast_i  (speed_100_i),
      .abort_i (!tx_enabled_i || full_duplex_i),                  // (RQ10) (RQ11)
      .busy_o  (jam_busy)
   );

   assign jam_o = jam_busy && tx_enabled_i;                       // (RQ11)

   // ----------------------------------------------------------------
   // Wishbone slave: one wait state, unmapped reads give zero
   // ----------------------------------------------------------------
   assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;

   always_comb begin
      cfg_d  = cfg_q;
      ack_d  = bus_req;
      rdat_d = 32'h0000_0000;
      if (bus_req && wb_we_i && wb_adr_i == CFG_OFS) begin
         for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
               cfg_d[b*8 +: 8] = wb_dat_i[b*8 +: 8] & CFG_WR_MASK[b*8 +: 8];
            end
         end
      end
      if (bus_req && !wb_we_i) begin
         case (wb_adr_i)
            CFG_OFS: begin
               rdat_d = cfg_q;
            end
            STAT_OFS: begin
               rdat_d[STAT_JAM_BIT]  = jam_o;
               rdat_d[STAT_PEND_BIT] = pend_q;
               rdat_d[STAT_HELD_BIT] = (st_q == ST_HELD);
               rdat_d[STAT_HI_BIT]   = hi_q;
               rdat_d[STAT_ZERO_BIT] = zero_q;
            end
            default: begin
               rdat_d = 32'h0000_0000;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_q  <= CFG_RST;
         rdat_q <= 32'h0000_0000;
         ack_q  <= 1'b0;
         st_q   <= ST_WATCH;
         pend_q <= 1'b0;
         zero_q <= 1'b0;
         hi_q   <= 1'b0;
      end else begin
         cfg_q  <= cfg_d;
         rdat_q <= rdat_d;
         ack_q  <= ack_d;
         st_q   <= st_d;
         pend_q <= pend_d;
         zero_q <= zero_d;
         hi_q   <= hi_d;
      end
   end

   assign wb_dat_o = rdat_q;
   assign wb_ack_o = ack_q;

endmodule

// ### tb/rfb_flow_ctl_sva.sv
// Assertion checker for the receive flow-control block
`timescale 1ns/1ps
module rfb_flow_ctl_sva
   import rfb_pkg::*;
#(
   parameter int unsigned FILL_W     = 14,           // Fill level width
   parameter int unsigned NS_PER_CYC = CLK_PERIOD_NS // Jam timer scaling
) (
   input wire logic              clk_i,           // Clock
   input wire logic              rst_i,           // Reset
   input wire logic              wb_cyc_i,        // Bus cycle
   input wire logic              wb_stb_i,        // Strobe
   input wire logic              wb_we_i,         // Write enable
   input wire logic [7:0]        wb_adr_i,        // Address
   input wire logic [3:0]        wb_sel_i,        // Byte lanes
   input wire logic [31:0]       wb_dat_i,        // Write data
   input wire logic [31:0]       wb_dat_o,        // Read data
   input wire logic              wb_ack_o,        // Acknowledge
   input wire logic [FILL_W-1:0] rx_fill_bytes_i, // Fill level
   input wire logic              full_duplex_i,   // Full duplex
   input wire logic              speed_100_i,     // Link speed
   input wire logic              tx_enabled_i,    // Transmitter on
   input wire logic              rx_preamble_i,   // Frame start
   input wire logic              pause_take_i,    // Pause taken
   input wire logic              pause_req_o,     // Pause wanted
   input wire logic              pause_zero_o,    // Zero-time pause
   input wire logic              jam_o            // Backpressure
);
   // ----------------------------------------------------------------
   // Shadow of the config word, so rules can be tied to settings
   // ----------------------------------------------------------------
   logic [31:0] cfg_q, cfg_d, lane_m;
   logic        hi_hit;
   assign lane_m = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign cfg_d = (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == CFG_OFS) ?
                  (cfg_q & ~(lane_m & CFG_WR_MASK)) | (wb_dat_i & lane_m & CFG_WR_MASK) : cfg_q;
   assign hi_hit = rx_fill_bytes_i >= {cfg_q[23:16], 6'h00};
   // Register only; the write decode lives above
   always_ff @(posedge clk_i) begin
      cfg_q <= rst_i ? CFG_RST : cfg_d;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   ack_due_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data leaks");
   pause_gate_a: assert property (pause_req_o |-> tx_enabled_i && cfg_q[CFG_ANY_BIT])
      else $error("pause without cause");
   jam_tx_a: assert property (jam_o |-> tx_enabled_i) else $error("jam with tx off");
   jam_fd_a: assert property (full_duplex_i |=> !jam_o) else $error("jam in full duplex");
   jam_start_a: assert property (rx_preamble_i && cfg_q[CFG_ANY_BIT] && !full_duplex_i &&
      tx_enabled_i && hi_hit && !jam_o |=> jam_o) else $error("jam not started");
   jam_cause_a: assert property (!jam_o && !rx_preamble_i |=> !jam_o)
      else $error("jam without preamble");
   pause_hold_a: assert property (pause_req_o && !pause_take_i && tx_enabled_i |=>
      pause_req_o && $stable(pause_zero_o)) else $error("pause dropped");
   jam_seen_c: cover property ($rose(jam_o));
   zero_seen_c: cover property (pause_req_o && pause_zero_o);
   take_seen_c: cover property (pause_req_o && pause_take_i);
endmodule

bind rfb_flow_ctl rfb_flow_ctl_sva #(.FILL_W(FILL_W), .NS_PER_CYC(NS_PER_CYC)) sva_u (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .rx_fill_bytes_i(rx_fill_bytes_i), .full_duplex_i(full_duplex_i),
   .speed_100_i(speed_100_i), .tx_enabled_i(tx_enabled_i), .rx_preamble_i(rx_preamble_i),
   .pause_take_i(pause_take_i), .pause_req_o(pause_req_o), .pause_zero_o(pause_zero_o),
   .jam_o(jam_o));

// ### tb/rfb_link_partner.sv
// Link partner model: starts frames and sends pending pause frames between them
`timescale 1ns/1ps
module rfb_link_partner (
   input  wire logic       clk_i,       // Clock
   input  wire logic       rst_i,       // Reset
   input  wire logic       frame_i,     // Bench asks for a frame
   input  wire logic [2:0] take_dly_i,  // Frame time left before a pause fits
   input  wire logic       pause_req_i, // Pause wanted
   output logic            preamble_o,  // Frame start pulse
   output logic            take_o       // Pause sent
);
   logic [2:0] wait_q; // Cycles of the frame waited out so far
   // The pause waits out the frame in progress, never cuts it short
   always @(posedge clk_i) begin
      preamble_o <= frame_i && !rst_i;
      if (rst_i || !pause_req_i || take_o) begin
         wait_q <= 3'h0;
         take_o <= 1'b0;
      end else if (wait_q == take_dly_i) begin
         take_o <= 1'b1;
      end else begin
         wait_q <= wait_q + 3'h1;
      end
   end
endmodule

// ### tb/rx_flow_backpressure_ctl_tb.sv
// Self-checking bench for the receive flow-control block
`timescale 1ns/1ps
module rx_flow_backpressure_ctl_tb;
   import rfb_pkg::*;
   localparam int unsigned NSPC = 200; // Shrinks jam times; all of them divide exactly
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic        fd = 1'b0, sp = 1'b1, tx = 1'b1, go = 1'b0, pre, take, preq, pz, jam, j;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, q, r;
   logic [13:0] fill = 14'h0000;
   logic [2:0]  dly = 3'h0;
   int          fails = 0, checks_done = 0, n, k;
   always #12.5 clk_i = ~clk_i;
   rfb_flow_ctl #(.NS_PER_CYC(NSPC)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .rx_fill_bytes_i(fill), .full_duplex_i(fd),
      .speed_100_i(sp), .tx_enabled_i(tx), .rx_preamble_i(pre), .pause_take_i(take),
      .pause_req_o(preq), .pause_zero_o(pz), .jam_o(jam));
   rfb_link_partner lp_u (.clk_i(clk_i), .rst_i(rst_i), .frame_i(go), .take_dly_i(dly),
      .pause_req_i(preq), .preamble_o(pre), .take_o(take));
   // ----------------------------------------------------------------
   // Expectations and shared tasks
   // ----------------------------------------------------------------
   function automatic int exp_cyc(input logic [3:0] c, input logic f);
      int ns;
      ns = (c < 4'h3) ? (c + 1) * 5000 : (c == 4'h3) ? 25000 : (c - 3) * 50000;
      return (f ? ns : ns + 2200) / NSPC;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic hang;
      fails++;
      $display("unexpected at %0t: wait ran out", $time);
      end_sim;
   endtask
   // One classic cycle; held until ack is sampled, then a gap cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d);
      int t;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
      t = 0;
      do begin @(posedge clk_i); t++; end while (ack !== 1'b1 && t < 20);
      if (ack !== 1'b1) hang;
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic cfg(input logic any, input logic [3:0] c);
      wb(1'b1, CFG_OFS, 4'hF, {8'h00, 8'h02, 8'h01, c, 3'h0, any}); // marks 128 and 64
   endtask
   task automatic frame;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
   endtask
   // Wait until the pause request has been taken, noting any jam meanwhile
   task automatic wait_take;
      k = 0;
      j = 1'b0;
      while (preq === 1'b1 && k < 20) begin @(posedge clk_i); j |= jam; k++; end
      if (preq === 1'b1) hang;
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h4834470D));
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, CFG_OFS, 4'hF, 32'h0); chk(q, CFG_RST);
      r = $urandom;
      wb(1'b1, CFG_OFS, 4'h5, r);
      wb(1'b1, 8'h0C, 4'hF, 32'hFFFFFFFF);
      wb(1'b0, CFG_OFS, 4'hF, 32'h0); chk(q, r & 32'h00FF00F1);
      wb(1'b0, 8'h0C, 4'hF, 32'h0); chk(q, 32'h0);
      // Every code at both speeds, with a stray preamble mid-jam
      for (int s = 0; s < 2; s++) for (int c = 0; c < 16; c++) begin
         sp <= s[0];
         fill <= 14'h0080 + 14'($urandom_range(0, 999));
         cfg(1'b1, c[3:0]);
         frame;
         k = 0;
         while (jam !== 1'b1 && k < 8) begin @(posedge clk_i); k++; end
         n = 0;
         while (jam === 1'b1 && n < 7000) begin go <= (n == 3); n++; @(posedge clk_i); end
         go <= 1'b0;
         chk(n, exp_cyc(c[3:0], s[0]));
      end
      // A long jam shows in status; dropping the transmitter cuts it short
      @(posedge clk_i);
      frame;
      repeat (3) @(posedge clk_i);
      wb(1'b0, STAT_OFS, 4'hF, 32'h0);
      chk(q, (32'h0000_0001 << STAT_JAM_BIT) | (32'h0000_0001 << STAT_HI_BIT));
      tx <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(jam, 1'b0);
      // Option off, one byte short of the mark, transmitter off
      for (int t = 0; t < 3; t++) begin
         cfg(t != 0, 4'h0);
         fill <= (t == 1) ? 14'h007F : 14'h0080;
         tx <= (t != 2);
         frame;
         j = 1'b0;
         repeat (6) begin @(posedge clk_i); j |= jam; end
         chk(j, 1'b0);
      end
      // Full duplex pause and its zero-time follow-up
      tx <= 1'b1; fd <= 1'b1; fill <= 14'h0040; dly <= 3'($urandom_range(0, 7));
      cfg(1'b1, 4'($urandom));
      chk(preq, 1'b0);
      fill <= 14'h0080 + 14'($urandom_range(0, 999));
      @(posedge clk_i);
      chk(preq, 1'b1);
      chk(pz, 1'b0);
      frame;
      wait_take;
      chk(j, 1'b0);
      wb(1'b0, STAT_OFS, 4'hF, 32'h0);
      chk(q, (32'h0000_0001 << STAT_HELD_BIT) | (32'h0000_0001 << STAT_HI_BIT));
      fill <= 14'h0040;
      repeat (3) @(posedge clk_i);
      chk(preq, 1'b0);
      fill <= 14'h003F;
      @(posedge clk_i);
      chk(preq, 1'b1);
      chk(pz, 1'b1);
      wait_take;
      wb(1'b0, STAT_OFS, 4'hF, 32'h0);
      chk(q, 32'h0000_0001 << STAT_ZERO_BIT);
      fill <= 14'h0000;
      cfg(1'b0, 4'h0);
      fill <= 14'h0080;
      repeat (3) @(posedge clk_i);
      chk(preq, 1'b0);
      tx <= 1'b0;
      cfg(1'b1, 4'h0);
      repeat (3) @(posedge clk_i);
      chk(preq, 1'b0);
      end_sim;
   end
endmodule
